// >>> hdl/pxro_regs.svh
`ifndef PXRO_REGS_SVH
`define PXRO_REGS_SVH
// Row pointer width and last row of the full frame
`define PXRO_ROW_W 10
`define PXRO_ROW_LAST 1023
// Column pointer counts groups of 32 columns, 40 groups to a full line
`define PXRO_COL_W 6
`define PXRO_COL_LAST 39
// Internal column bus and output count
`define PXRO_BUS_COLS 32
`define PXRO_OUT_COUNT 16
// Serial word: row field above column field, MSB first
`define PXRO_SER_LEN 16
`define PXRO_SER_ROW_LSB 6
`define PXRO_SER_COL_LSB 0
// Reset values of start address registers
`define PXRO_ROW_START_RST 10'h000
`define PXRO_COL_START_RST 6'h00
// Width of one pixel sample on the output model
`define PXRO_PIX_W 8
// Count of synchronised pins
`define PXRO_PIN_COUNT 13
`endif

// >>> hdl/pxro_pkg.sv
package pxro_pkg;
  // Pixel memory sampling sequence
  typedef enum logic [1:0] {
    MEM_EMPTY,
    MEM_CLEARED,
    MEM_SAMPLING,
    MEM_HELD
  } pxro_mem_t;
endpackage : pxro_pkg

// >>> hdl/pxro_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module pxro_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) $error("pxro_sync2: WIDTH must be at least 1");
  end

  // Two flip-flop synchroniser; meta feeds only q_out
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule : pxro_sync2
`default_nettype wire

// >>> hdl/pxro_serial_addr.sv
`timescale 1ns/1ps
`default_nettype none
`include "pxro_regs.svh"
module pxro_serial_addr #(
  parameter int LEN = `PXRO_SER_LEN
) (
  input wire logic serial_load_clock_in,
  input wire logic rst_in,
  input wire logic address_in,
  output logic [LEN-1:0] shift_word_out
);
  logic rst_meta;
  logic rst_link;

  initial begin
    if (LEN < 2) $error("pxro_serial_addr: LEN must be at least 2");
  end

  // Reset brought into the serial clock domain
  always_ff @(posedge serial_load_clock_in) begin
    rst_meta <= rst_in;
    rst_link <= rst_meta;
  end

  // One address bit per rising serial edge, MSB first
  always_ff @(posedge serial_load_clock_in) begin
    if (rst_link) begin
      shift_word_out <= '0;
    end else begin
      shift_word_out <= {shift_word_out[LEN-2:0], address_in};
    end
  end
endmodule : pxro_serial_addr
`default_nettype wire

// >>> hdl/pxro_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pxro_regs.svh"
module pxro_top #(
  parameter int ROW_W = `PXRO_ROW_W,
  parameter int COL_W = `PXRO_COL_W,
  parameter int ROW_LAST = `PXRO_ROW_LAST,
  parameter int COL_LAST = `PXRO_COL_LAST,
  parameter int PIX_W = `PXRO_PIX_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic serial_load_clock_in,
  input wire logic address_in,
  input wire logic window_start_load_in,
  input wire logic frame_sync_in,
  input wire logic row_step_clock_in,
  input wire logic line_sync_in,
  input wire logic column_step_clock_in,
  input wire logic [`PXRO_BUS_COLS*PIX_W-1:0] column_bus_in,
  input wire logic memory_clear_pulse_in,
  input wire logic sample_pulse_in,
  input wire logic memory_boost_level_in,
  input wire logic main_reset_pulse_in,
  input wire logic second_slope_reset_in,
  input wire logic column_hold_in,
  input wire logic row_deselect_pulse_in,
  input wire logic output_load_enable_in,
  output logic [ROW_W-1:0] row_select_out,
  output logic [COL_W-1:0] column_group_out,
  output logic [`PXRO_OUT_COUNT*PIX_W-1:0] pixel_outputs_out,
  output logic line_end_flag_out,
  output logic frame_end_flag_out,
  output logic precharge_drive_out,
  output logic sample_drive_out,
  output logic memory_level_high_out,
  output logic pixel_reset_drive_out,
  output logic reset_level_high_out,
  output logic column_hold_drive_out,
  output logic row_deselect_drive_out,
  output logic active_load_on_out,
  output logic memory_valid_out,
  output pxro_pkg::pxro_mem_t memory_state_out
);
  import pxro_pkg::*;

  localparam int HALF = `PXRO_OUT_COUNT * PIX_W;

  logic [`PXRO_PIN_COUNT-1:0] pins_raw;
  logic [`PXRO_PIN_COUNT-1:0] pins;
  logic [`PXRO_SER_LEN-1:0] shift_word;
  logic fsync, lsync, row_clk, col_clk, load, clear, sample;
  logic boost, mreset, dslope, hold, norow, oload;
  logic row_clk_d, col_clk_d, load_d, clear_d;
  logic row_rise, col_rise, col_fall, load_rise, clear_rise;
  logic [ROW_W-1:0] row_start;
  logic [COL_W-1:0] col_start;
  logic [ROW_W-1:0] next_row;
  logic [COL_W-1:0] next_col;
  logic frame_active;
  logic line_active;

  initial begin
    if (ROW_W < 1 || ROW_LAST >= (1 << ROW_W)) $error("pxro_top: bad row size");
    if (COL_W < 1 || COL_LAST >= (1 << COL_W)) $error("pxro_top: bad column size");
    if (`PXRO_SER_LEN != ROW_W + COL_W) $error("pxro_top: serial length mismatch");
    if (PIX_W < 1) $error("pxro_top: PIX_W must be at least 1");
  end

  // Every control pin except the serial clock and address passes two flip-flops before use
  assign pins_raw = {frame_sync_in, line_sync_in, row_step_clock_in,
                     column_step_clock_in, window_start_load_in,
                     memory_clear_pulse_in, sample_pulse_in,
                     memory_boost_level_in, main_reset_pulse_in,
                     second_slope_reset_in, column_hold_in,
                     row_deselect_pulse_in, output_load_enable_in};

  pxro_sync2 #(.WIDTH(`PXRO_PIN_COUNT)) u_pin_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(pins_raw),
    .q_out(pins)
  );

  assign {fsync, lsync, row_clk, col_clk, load, clear, sample,
          boost, mreset, dslope, hold, norow, oload} = pins;

  // Serial address shift register on its own clock
  pxro_serial_addr #(.LEN(`PXRO_SER_LEN)) u_serial (
    .serial_load_clock_in(serial_load_clock_in),
    .rst_in(rst_in),
    .address_in(address_in),
    .shift_word_out(shift_word)
  );

  // Previous values for edge detection
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      row_clk_d <= 1'b0;
      col_clk_d <= 1'b0;
      load_d <= 1'b0;
      clear_d <= 1'b0;
    end else begin
      row_clk_d <= row_clk;
      col_clk_d <= col_clk;
      load_d <= load;
      clear_d <= clear;
    end
  end

  assign row_rise = row_clk & ~row_clk_d;
  assign col_rise = col_clk & ~col_clk_d;
  assign col_fall = ~col_clk & col_clk_d;
  assign load_rise = load & ~load_d;
  assign clear_rise = clear & ~clear_d;

  // Start registers; word is quiet once the strobe arrives, so it is taken as a whole
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      row_start <= `PXRO_ROW_START_RST;
      col_start <= `PXRO_COL_START_RST;
    end else if (load_rise) begin
      row_start <= shift_word[`PXRO_SER_ROW_LSB +: ROW_W];
      col_start <= shift_word[`PXRO_SER_COL_LSB +: COL_W];
    end
  end

  // Next row: sync loads start, otherwise step by one and stop at the last row
  always_comb begin
    if (fsync) begin
      next_row = row_start;
    end else if (row_select_out != ROW_W'(ROW_LAST)) begin
      next_row = row_select_out + 1'b1;
    end else begin
      next_row = row_select_out;
    end
  end

  // Row pointer moves only on a rising row step edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      row_select_out <= '0;
      frame_active <= 1'b0;
    end else if (row_rise) begin
      row_select_out <= next_row;
      if (fsync) begin
        frame_active <= 1'b1;
      end
    end
  end

  // Next column group, same scheme as the rows
  always_comb begin
    if (lsync) begin
      next_col = col_start;
    end else if (column_group_out != COL_W'(COL_LAST)) begin
      next_col = column_group_out + 1'b1;
    end else begin
      next_col = column_group_out;
    end
  end

  // Column pointer moves on a rising column step edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      column_group_out <= '0;
      line_active <= 1'b0;
    end else if (col_rise) begin
      column_group_out <= next_col;
      if (lsync) begin
        line_active <= 1'b1;
      end
    end
  end

  // Pixel outputs: low half of the bus on rising, high half on falling
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pixel_outputs_out <= '0;
    end else if (col_rise) begin
      pixel_outputs_out <= column_bus_in[HALF-1:0];
    end else if (col_fall) begin
      pixel_outputs_out <= column_bus_in[2*HALF-1:HALF];
    end
  end

  // End flags only while the matching start register holds address zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      line_end_flag_out <= 1'b0;
      frame_end_flag_out <= 1'b0;
    end else begin
      line_end_flag_out <= line_active && col_start == '0 &&
                           column_group_out == COL_W'(COL_LAST);
      frame_end_flag_out <= frame_active && row_start == '0 &&
                            row_select_out == ROW_W'(ROW_LAST);
    end
  end

  // Pixel memory sequence: clear, then sample, then held for readout
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      memory_state_out <= MEM_EMPTY;
    end else begin
      case (memory_state_out)
        MEM_EMPTY, MEM_HELD: begin
          if (clear_rise) begin
            memory_state_out <= MEM_CLEARED;
          end
        end
        MEM_CLEARED: begin
          if (sample && !clear) begin
            memory_state_out <= MEM_SAMPLING;
          end
        end
        MEM_SAMPLING: begin
          if (!sample) begin
            memory_state_out <= MEM_HELD;
          end
        end
        default: begin
          memory_state_out <= MEM_EMPTY;
        end
      endcase
    end
  end

  assign memory_valid_out = (memory_state_out == MEM_HELD);

  // Pixel drive levels follow the synchronised controls; sample drive stays low while memory is MEM_EMPTY
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      precharge_drive_out <= 1'b0;
      sample_drive_out <= 1'b0;
      memory_level_high_out <= 1'b0;
    end else begin
      precharge_drive_out <= clear;
      sample_drive_out <= sample && memory_state_out != MEM_EMPTY;
      memory_level_high_out <= boost;
    end
  end

  // Reset drive: main reset at high level dominates the second slope
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pixel_reset_drive_out <= 1'b0;
      reset_level_high_out <= 1'b1;
    end else begin
      pixel_reset_drive_out <= mreset | dslope;
      reset_level_high_out <= mreset | ~dslope;
    end
  end

  // Column readout controls and output stage load
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      column_hold_drive_out <= 1'b0;
      row_deselect_drive_out <= 1'b0;
      active_load_on_out <= 1'b0;
    end else begin
      column_hold_drive_out <= hold;
      row_deselect_drive_out <= norow;
      active_load_on_out <= oload;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_row_sync_edge;
    row_rise && fsync;
  endsequence

  sequence s_col_sync_edge;
    col_rise && lsync;
  endsequence

  sequence s_sample_done;
    memory_state_out == MEM_SAMPLING && !sample;
  endsequence

  property p_row_start;
    s_row_sync_edge |=> row_select_out == $past(row_start);
  endproperty
  a_row_start: assert property (p_row_start)
    else $error("row pointer did not load start on frame sync");

  property p_row_step;
    row_rise && !fsync && row_select_out != ROW_W'(ROW_LAST)
      |=> row_select_out == $past(row_select_out) + 1'b1;
  endproperty
  a_row_step: assert property (p_row_step)
    else $error("row pointer did not advance by one");

  property p_col_start;
    s_col_sync_edge |=> column_group_out == $past(col_start);
  endproperty
  a_col_start: assert property (p_col_start)
    else $error("column pointer did not load start on line sync");

  property p_hold_pointer;
    load_rise && !row_rise |=> row_select_out == $past(row_select_out);
  endproperty
  a_hold_pointer: assert property (p_hold_pointer)
    else $error("address load disturbed the row scan");

  property p_line_end;
    line_end_flag_out |-> $past(col_start) == '0 &&
      $past(column_group_out) == COL_W'(COL_LAST);
  endproperty
  a_line_end: assert property (p_line_end)
    else $error("line end flag outside full line end");

  property p_frame_end;
    frame_end_flag_out |-> $past(row_start) == '0 &&
      $past(row_select_out) == ROW_W'(ROW_LAST);
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("frame end flag outside full frame end");

  property p_halves;
    col_fall |=> pixel_outputs_out == $past(column_bus_in[2*HALF-1:HALF]);
  endproperty
  a_halves: assert property (p_halves)
    else $error("falling column edge did not show high half");

  property p_reset_priority;
    mreset && dslope |=> pixel_reset_drive_out && reset_level_high_out;
  endproperty
  a_reset_priority: assert property (p_reset_priority)
    else $error("main reset did not win over second slope");

  property p_second_slope;
    dslope && !mreset |=> pixel_reset_drive_out && !reset_level_high_out;
  endproperty
  a_second_slope: assert property (p_second_slope)
    else $error("second slope reset not at low level");

  property p_memory_held;
    s_sample_done |=> memory_valid_out ##1 memory_state_out != MEM_SAMPLING;
  endproperty
  a_memory_held: assert property (p_memory_held)
    else $error("memory not held after sample");

  property p_boost;
    boost |=> memory_level_high_out;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost level not applied");
endmodule : pxro_top
`default_nettype wire

// >>> testbench/pxro_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module pxro_ctl_model (
  input wire logic clk_in,
  output var logic serial_load_clock_out,
  output var logic address_out,
  output var logic window_start_load_out,
  output var logic frame_sync_out,
  output var logic row_step_clock_out,
  output var logic line_sync_out,
  output var logic column_step_clock_out
);
  // Idle levels of the controller pins
  initial begin
    serial_load_clock_out = 1'b0;
    address_out = 1'b0;
    window_start_load_out = 1'b0;
    frame_sync_out = 1'b0;
    row_step_clock_out = 1'b0;
    line_sync_out = 1'b0;
    column_step_clock_out = 1'b0;
  end
  // Land just after a falling system edge
  task automatic settle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : settle
  // Burst of n bits, MSB first; the serial clock stands still outside it
  task automatic shift(input logic [15:0] word, input int n);
    #3;
    for (int i = 15; i > 15 - n; i--) begin
      address_out = word[i];
      #6 serial_load_clock_out = 1'b1;
      #6 serial_load_clock_out = 1'b0;
    end
    address_out = ~address_out; // Released line no longer shows the last bit
  endtask : shift
  // Strobe only once the full word is in; no serial edges meanwhile
  task automatic load();
    settle(1);
    window_start_load_out = 1'b1;
    settle(3);
    window_start_load_out = 1'b0;
    settle(4);
  endtask : load
  // Move the row or the column step clock to a level
  task automatic step(input logic row, input logic level);
    settle(1);
    if (row) begin
      row_step_clock_out = level;
    end else begin
      column_step_clock_out = level;
    end
    settle(5);
  endtask : step
  // Sync pulse that covers exactly one rising step edge
  task automatic sync(input logic row);
    settle(1);
    if (row) begin
      frame_sync_out = 1'b1;
    end else begin
      line_sync_out = 1'b1;
    end
    settle(3);
    step(row, 1'b1);
    frame_sync_out = 1'b0;
    line_sync_out = 1'b0;
    settle(3);
    step(row, 1'b0);
  endtask : sync
endmodule : pxro_ctl_model
`default_nettype wire

// >>> testbench/tb_pixel_array_readout_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pixel_array_readout_control;
  import pxro_pkg::*;
  localparam int ROW_LAST = 7;
  localparam int COL_LAST = 5;
  logic clk_in, rst_in, sclk, addr, wload, fsync, rstep, lsync, cstep;
  logic [255:0] col_bus;
  logic clear, sample, boost, main_rst, second, hold, desel, oload;
  logic [9:0] row_sel;
  logic [5:0] col_grp;
  logic [127:0] pix;
  logic line_end, frame_end, pre_drv, smp_drv, mem_high, rst_drv, lvl_high;
  logic hold_drv, desel_drv, load_on, mem_valid;
  pxro_mem_t mem_state;
  int failures = 0;
  int total_checks = 0;
  // Rows: {boost, main, second, hold, deselect, load} then expected drives
  logic [11:0] rows [5] = '{12'h869, 12'h314, 12'h49a, 12'h618, 12'h008};

  pxro_top #(.ROW_LAST(ROW_LAST), .COL_LAST(COL_LAST)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .serial_load_clock_in(sclk), .address_in(addr),
    .window_start_load_in(wload), .frame_sync_in(fsync), .row_step_clock_in(rstep),
    .line_sync_in(lsync), .column_step_clock_in(cstep), .column_bus_in(col_bus),
    .memory_clear_pulse_in(clear), .sample_pulse_in(sample),
    .memory_boost_level_in(boost), .main_reset_pulse_in(main_rst),
    .second_slope_reset_in(second), .column_hold_in(hold),
    .row_deselect_pulse_in(desel), .output_load_enable_in(oload),
    .row_select_out(row_sel), .column_group_out(col_grp), .pixel_outputs_out(pix),
    .line_end_flag_out(line_end), .frame_end_flag_out(frame_end),
    .precharge_drive_out(pre_drv), .sample_drive_out(smp_drv),
    .memory_level_high_out(mem_high), .pixel_reset_drive_out(rst_drv),
    .reset_level_high_out(lvl_high), .column_hold_drive_out(hold_drv),
    .row_deselect_drive_out(desel_drv), .active_load_on_out(load_on),
    .memory_valid_out(mem_valid), .memory_state_out(mem_state)
  );
  pxro_ctl_model ctl (
    .clk_in(clk_in), .serial_load_clock_out(sclk), .address_out(addr),
    .window_start_load_out(wload), .frame_sync_out(fsync), .row_step_clock_out(rstep),
    .line_sync_out(lsync), .column_step_clock_out(cstep)
  );

  // System clock, 25 ns period
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Compare one value and count it
  task automatic chk(input string name, input logic [159:0] got, input logic [159:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Cut a hang short
  initial begin
    #(20000 * 25);
    failures++;
    complete_run();
  end

  // Main sequence
  initial begin
    rst_in = 1'b1;
    {clear, sample, boost, main_rst, second, hold, desel, oload} = 8'h00;
    for (int c = 0; c < 32; c++) begin
      col_bus[c*8 +: 8] = 8'h20 + 8'(c);
    end
    fork
      ctl.shift(16'h0000, 4);
      repeat (6) @(posedge clk_in);
    join
    @(negedge clk_in);
    chk("reset outs", {lvl_high, rst_drv, pre_drv, smp_drv, load_on, line_end, frame_end,
        row_sel, col_grp}, 23'h400000);
    chk("reset state", mem_state, MEM_EMPTY);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    // Level inputs against their drives
    foreach (rows[i]) begin
      {boost, main_rst, second, hold, desel, oload} = rows[i][11:6];
      repeat (6) @(negedge clk_in);
      chk("drives", {mem_high, rst_drv, lvl_high, hold_drv, desel_drv, load_on},
          rows[i][5:0]);
    end
    // Clear then sample the pixel memories
    clear = 1'b1;
    repeat (6) @(negedge clk_in);
    chk("cleared", {mem_state, pre_drv}, {MEM_CLEARED, 1'b1});
    clear = 1'b0;
    sample = 1'b1;
    repeat (6) @(negedge clk_in);
    chk("sampling", {mem_state, smp_drv}, {MEM_SAMPLING, 1'b1});
    sample = 1'b0;
    repeat (6) @(negedge clk_in);
    chk("held", {mem_state, mem_valid}, {MEM_HELD, 1'b1});
    // Full frame from start zero
    ctl.shift(16'h0000, 16);
    ctl.load();
    ctl.sync(1'b1);
    chk("frame start", {frame_end, row_sel}, 11'h000);
    for (int r = 1; r <= ROW_LAST; r++) begin
      ctl.step(1'b1, 1'b1);
      chk("row step", {frame_end, row_sel}, {1'(r == ROW_LAST), 10'(r)});
      ctl.step(1'b1, 1'b0);
    end
    // Full line, both halves of the column bus
    ctl.sync(1'b0);
    chk("line start", {col_grp, pix}, {6'h00, col_bus[255:128]});
    for (int c = 1; c <= COL_LAST; c++) begin
      ctl.step(1'b0, 1'b1);
      chk("col rise", {line_end, col_grp, pix},
          {1'(c == COL_LAST), 6'(c), col_bus[127:0]});
      ctl.step(1'b0, 1'b0);
      chk("col fall", pix, col_bus[255:128]);
    end
    // New window loaded mid-scan waits for the syncs
    ctl.shift({10'h005, 6'h03}, 16);
    ctl.load();
    chk("scan kept", {row_sel, col_grp}, {10'(ROW_LAST), 6'(COL_LAST)});
    ctl.sync(1'b1);
    ctl.sync(1'b0);
    chk("window start", {frame_end, line_end, row_sel, col_grp},
        {2'b00, 10'h005, 6'h03});
    for (int k = 0; k < 8; k++) begin
      ctl.step(1'b1, 1'b1);
      ctl.step(1'b0, 1'b1);
      ctl.step(1'b1, 1'b0);
      ctl.step(1'b0, 1'b0);
    end
    chk("window ends", {frame_end, line_end, row_sel, col_grp},
        {2'b00, 10'(ROW_LAST), 6'(COL_LAST)});
    chk("still held", mem_valid, 1'b1);
    // Reset in mid-run returns outputs and memory state to idle values
    rst_in = 1'b1;
    repeat (6) @(negedge clk_in);
    chk("mid reset outs", {lvl_high, rst_drv, pre_drv, smp_drv, load_on, line_end, frame_end,
        row_sel, col_grp}, 23'h400000);
    chk("mid reset state", {mem_state, mem_valid, pix}, {MEM_EMPTY, 1'b0, 128'h0});
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("after reset", {row_sel, col_grp, line_end, frame_end, mem_valid}, 19'h00000);
    complete_run();
  end
endmodule : tb_pixel_array_readout_control
`default_nettype wire
